/* rtl/ocsl_device.sv */
// Purpose: Sensor end: loads, overrides, burns and reads back the configuration word.
// Assumes: Link pins are asynchronous; nrst stands for the power-on reset.
// Notes:   The fuse array lives outside; this end reads it and issues burn pulses.
`timescale 1ns/1ps
`include "ocsl_defs.svh"

module ocsl_device #(
   parameter int STEP_NS = `OCSL_STEP_NS,
   parameter int CLK_MHZ = `OCSL_CLK_MHZ
) (
   input  wire logic                clock,
   input  wire logic                nrst,
   ocsl_if.dev                      link,
   input  wire ocsl_pkg::ocsl_word_t fuseBits,
   output logic                     fuseBurn,
   output ocsl_pkg::ocsl_word_t     fuseBurnData,
   output ocsl_pkg::ocsl_word_t     activeCfg,
   input  wire logic [11:0]         rawAngle,
   input  wire logic                movingCloser,
   input  wire logic                movingAway,
   input  wire logic                fieldOut,
   input  wire logic                fieldRed,
   input  wire logic                linRaw,
   output logic [11:0]              angle,
   output logic                     pwmOut,
   output logic                     fieldRiseFlag,
   output logic                     fieldFallFlag,
   output logic                     linAlarm
);
   import ocsl_pkg::*;

   localparam int         STEP_CYC  = (STEP_NS * CLK_MHZ) / 1000;
   localparam logic [9:0] STEP_LAST = 10'(STEP_CYC - 1);
   localparam logic [9:0] HALF_LAST = 10'(2 * STEP_CYC - 1);
   localparam logic [12:0] PWM_LAST = 13'(`OCSL_PWM_STEPS - 1);

   // Pin order: {progLevel, dataPin, serialClock, frameSelectN}.
   logic [3:0]      sync1_reg, sync2_reg, prev_reg;
   logic            csRise, csFall, clkRise, pinHigh, progHigh;
   ocsl_dev_state_t state_reg, state_next;
   ocsl_word_t      shift_reg, shift_next;
   ocsl_word_t      cfg_reg, cfg_next;
   ocsl_word_t      burnData_reg, burnData_next;
   logic [4:0]      bitCnt_reg, bitCnt_next;
   logic            loaded_reg, loaded_next;
   logic            burn_reg, burn_next;
   logic            devData_reg, devData_next;
   logic            devOe_reg, devOe_next;
   logic            ref_reg, ref_next;
   logic [11:0]     angle_reg, angle_next;
   logic            rise_reg, rise_next;
   logic            fall_reg, fall_next;
   logic            lin_reg, lin_next;
   logic [9:0]      pre_reg, pre_next;
   logic [12:0]     step_reg, step_next;
   logic            pwm_reg, pwm_next;
   logic [11:0]     zeroOffset;

   assign csRise   = sync2_reg[0] & ~prev_reg[0];
   assign csFall   = ~sync2_reg[0] & prev_reg[0];
   assign clkRise  = sync2_reg[1] & ~prev_reg[1];
   assign pinHigh  = sync2_reg[2];
   assign progHigh = sync2_reg[3];
   assign zeroOffset = cfg_reg[`OCSL_ZERO_MSB:`OCSL_ZERO_LSB];

   always_ff @(posedge clock) begin
      if (!nrst) begin
         sync1_reg <= 4'h1;
         sync2_reg <= 4'h1;
         prev_reg  <= 4'h1;
      end else begin
         sync1_reg <= {link.progLevel, link.dataPin, link.serialClock, link.frameSelectN};
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   always_comb begin
      state_next    = state_reg;
      shift_next    = shift_reg;
      cfg_next      = cfg_reg;
      burnData_next = burnData_reg;
      bitCnt_next   = bitCnt_reg;
      loaded_next   = 1'b1;
      burn_next     = 1'b0;
      devData_next  = devData_reg;
      devOe_next    = devOe_reg;
      ref_next      = ref_reg;
      // The fuse image is taken once after reset, so burns show only after power-up.
      if (!loaded_reg) begin
         cfg_next = fuseBits;
      end
      unique case (state_reg)
         DS_IDLE, DS_WRITTEN: begin
            // Serial clocks here are ignored on purpose; only select and level act.
            if (csRise && pinHigh) begin
               state_next  = DS_WRITE;
               bitCnt_next = 5'h00;
            end else if (state_reg == DS_WRITTEN && progHigh) begin
               state_next  = DS_BURN;
               bitCnt_next = 5'h00;
            end
         end
         DS_WRITE: begin
            if (csRise && bitCnt_reg == 5'h00) begin
               // The programmer has already released the pin by this edge.
               state_next   = DS_RB_EN;
               devOe_next   = 1'b1;
               devData_next = 1'b0;
            end else if (clkRise) begin
               shift_next  = {shift_reg[`OCSL_WORD_W-2:0], pinHigh};
               bitCnt_next = bitCnt_reg + 5'h01;
               if (bitCnt_reg == `OCSL_LAST_BIT) begin
                  cfg_next   = {shift_reg[`OCSL_WORD_W-2:0], pinHigh};
                  state_next = DS_WRITTEN;
               end
            end
         end
         DS_BURN: begin
            if (clkRise) begin
               burn_next     = 1'b1;
               // Masking burned bits keeps a fuse from being driven twice.
               burnData_next = shift_reg & ~fuseBits;
               bitCnt_next   = bitCnt_reg + 5'h01;
               if (bitCnt_reg == `OCSL_BURN_LAST) begin
                  state_next = DS_LOCKED;
               end
            end
         end
         DS_LOCKED: begin
            state_next = DS_LOCKED;
         end
         DS_RB_EN: begin
            if (csFall) begin
               state_next  = DS_RB_OUT;
               ref_next    = 1'b1;
               bitCnt_next = 5'h00;
            end
         end
         DS_RB_OUT: begin
            if (csRise && bitCnt_reg == `OCSL_RB_BITS) begin
               state_next = DS_IDLE;
               devOe_next = 1'b0;
            end else if (clkRise && bitCnt_reg != `OCSL_RB_BITS) begin
               ref_next     = 1'b0;
               devData_next = fuseBits[bitCnt_reg[3:0]];
               bitCnt_next  = bitCnt_reg + 5'h01;
            end
         end
         default: begin
            state_next = DS_IDLE;
            devOe_next = 1'b0;
            ref_next   = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         state_reg    <= DS_IDLE;
         shift_reg    <= 16'h0000;
         cfg_reg      <= 16'h0000;
         burnData_reg <= 16'h0000;
         bitCnt_reg   <= 5'h00;
         loaded_reg   <= 1'b0;
         burn_reg     <= 1'b0;
         devData_reg  <= 1'b0;
         devOe_reg    <= 1'b0;
         ref_reg      <= 1'b0;
      end else begin
         state_reg    <= state_next;
         shift_reg    <= shift_next;
         cfg_reg      <= cfg_next;
         burnData_reg <= burnData_next;
         bitCnt_reg   <= bitCnt_next;
         loaded_reg   <= loaded_next;
         burn_reg     <= burn_next;
         devData_reg  <= devData_next;
         devOe_reg    <= devOe_next;
         ref_reg      <= ref_next;
      end
   end

   always_comb begin
      if (cfg_reg[`OCSL_CCW_BIT]) begin
         angle_next = zeroOffset - rawAngle;
      end else begin
         angle_next = rawAngle - zeroOffset;
      end
      if (cfg_reg[`OCSL_FWIN_BIT]) begin
         rise_next = fieldOut | fieldRed;
         fall_next = fieldOut | fieldRed;
         lin_next  = fieldRed;
      end else begin
         rise_next = movingCloser | fieldOut;
         fall_next = movingAway | fieldOut;
         lin_next  = linRaw;
      end
      pre_next  = pre_reg + 10'h001;
      step_next = step_reg;
      if (pre_reg == (cfg_reg[`OCSL_HALVE_BIT] ? HALF_LAST : STEP_LAST)) begin
         pre_next  = 10'h000;
         step_next = (step_reg == PWM_LAST) ? 13'h0000 : step_reg + 13'h0001;
      end
      // High for angle+1 steps of a 4097-step period.
      pwm_next = ~cfg_reg[`OCSL_PWMDIS_BIT] & (step_reg <= {1'b0, angle_reg});
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         angle_reg <= 12'h000;
         rise_reg  <= 1'b0;
         fall_reg  <= 1'b0;
         lin_reg   <= 1'b0;
         pre_reg   <= 10'h000;
         step_reg  <= 13'h0000;
         pwm_reg   <= 1'b0;
      end else begin
         angle_reg <= angle_next;
         rise_reg  <= rise_next;
         fall_reg  <= fall_next;
         lin_reg   <= lin_next;
         pre_reg   <= pre_next;
         step_reg  <= step_next;
         pwm_reg   <= pwm_next;
      end
   end

   assign fuseBurn         = burn_reg;
   assign fuseBurnData     = burnData_reg;
   assign activeCfg        = cfg_reg;
   assign angle            = angle_reg;
   assign pwmOut           = pwm_reg;
   assign fieldRiseFlag    = rise_reg;
   assign fieldFallFlag    = fall_reg;
   assign linAlarm         = lin_reg;
   assign link.devData     = devData_reg;
   assign link.devDataOe   = devOe_reg;
   assign link.readbackRef = ref_reg;
endmodule

/* rtl/ocsl_defs.svh */
// Purpose: Named constants for the serial configuration port, both ends.
// Assumes: Included by every design file that needs a figure.
// Notes:   The word is shifted first bit first into bit 15.
`ifndef OCSL_DEFS_SVH
`define OCSL_DEFS_SVH

`define OCSL_WORD_W       16
`define OCSL_CCW_BIT      15
`define OCSL_ZERO_MSB     14
`define OCSL_ZERO_LSB     3
`define OCSL_PWMDIS_BIT   2
`define OCSL_FWIN_BIT     1
`define OCSL_HALVE_BIT    0
`define OCSL_LAST_BIT     5'h0F
`define OCSL_BURN_LAST    5'h0F
`define OCSL_RB_BITS      5'h10
`define OCSL_CLK_MHZ      250
`define OCSL_STEP_NS      1000
`define OCSL_PWM_STEPS    4097

`define OCSL_REG_CTRL     8'h00
`define OCSL_REG_CFG      8'h04
`define OCSL_REG_STATUS   8'h08
`define OCSL_REG_RB       8'h0C
`define OCSL_REG_DIV      8'h10
`define OCSL_CMD_WRITE    0
`define OCSL_CMD_BURN     1
`define OCSL_CMD_READ     2
`define OCSL_DIV_RESET    16'h0014

`endif

/* rtl/ocsl_pkg.sv */
// Purpose: Types shared by both ends of the serial configuration port.
// Assumes: Constants come from ocsl_defs.svh.
// Notes:   State codes are one-hot.
package ocsl_pkg;
   typedef logic [15:0] ocsl_word_t;

   typedef enum logic [6:0] {
      DS_IDLE    = 7'h01,
      DS_WRITE   = 7'h02,
      DS_WRITTEN = 7'h04,
      DS_BURN    = 7'h08,
      DS_LOCKED  = 7'h10,
      DS_RB_EN   = 7'h20,
      DS_RB_OUT  = 7'h40
   } ocsl_dev_state_t;

   typedef enum logic [7:0] {
      HS_IDLE   = 8'h01,
      HS_PRE    = 8'h02,
      HS_ENTER  = 8'h04,
      HS_RBDROP = 8'h08,
      HS_RBEN   = 8'h10,
      HS_RBANA  = 8'h20,
      HS_CLKLO  = 8'h40,
      HS_CLKHI  = 8'h80
   } ocsl_host_state_t;

   typedef enum logic [1:0] {
      HM_WRITE = 2'h0,
      HM_BURN  = 2'h1,
      HM_READ  = 2'h2
   } ocsl_host_mode_t;
endpackage

/* rtl/ocsl_if.sv */
// Purpose: Pins between the programmer and the sensor's configuration port.
// Assumes: Each end drives only its own signals; the data pin is resolved here.
// Notes:   An undriven data pin reads low, as if pulled down.
`timescale 1ns/1ps
interface ocsl_if;
   logic frameSelectN;
   logic serialClock;
   logic hostData;
   logic hostDataOe;
   logic progLevel;
   logic devData;
   logic devDataOe;
   logic readbackRef;
   logic dataPin;

   // Both enables high is a collision; the programmer wins so it stays visible.
   assign dataPin = hostDataOe ? hostData : (devDataOe ? devData : 1'b0);

   modport dev (
      input  frameSelectN,
      input  serialClock,
      input  dataPin,
      input  progLevel,
      output devData,
      output devDataOe,
      output readbackRef
   );

   modport host (
      output frameSelectN,
      output serialClock,
      output hostData,
      output hostDataOe,
      output progLevel,
      input  dataPin,
      input  readbackRef
   );
endinterface

/* rtl/ocsl_host.sv */
// Purpose: Programmer end: AHB-Lite registers drive write, burn and readback sequences.
// Assumes: Single-word AHB-Lite transfers; this end makes the serial clock by a divider.
// Notes:   Zero wait states; every response is OKAY.
`timescale 1ns/1ps
`include "ocsl_defs.svh"

module ocsl_host (
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   ocsl_if.host             link
);
   import ocsl_pkg::*;

   ocsl_host_state_t state_reg, state_next;
   ocsl_host_mode_t  mode_reg, mode_next;
   ocsl_word_t       cfg_reg, cfg_next;
   ocsl_word_t       rb_reg, rb_next;
   logic [15:0]      div_reg, div_next;
   logic [15:0]      divCnt_reg, divCnt_next;
   logic [3:0]       cnt_reg, cnt_next;
   logic [3:0]       nxt;
   logic             csN_reg, csN_next;
   logic             sclk_reg, sclk_next;
   logic             hdata_reg, hdata_next;
   logic             hoe_reg, hoe_next;
   logic             prog_reg, prog_next;
   logic             pin1_reg, pin2_reg;
   logic             wrPend_reg, wrPend_next;
   logic [7:0]       addr_reg, addr_next;
   logic [31:0]      hrdata_reg, hrdata_next;
   logic             busy, tick, start;

   assign busy  = (state_reg != HS_IDLE);
   assign tick  = busy && (divCnt_reg == div_reg - 16'h0001);
   assign start = wrPend_reg && (addr_reg == `OCSL_REG_CTRL) && !busy;
   assign nxt   = cnt_reg + 4'h1;

   always_comb begin
      wrPend_next = 1'b0;
      addr_next   = addr_reg;
      hrdata_next = hrdata_reg;
      cfg_next    = cfg_reg;
      div_next    = div_reg;
      if (hsel && hready && htrans[1]) begin
         wrPend_next = hwrite;
         addr_next   = haddr[7:0];
         if (!hwrite) begin
            case (haddr[7:0])
               `OCSL_REG_CFG:    hrdata_next = {16'h0000, cfg_reg};
               `OCSL_REG_STATUS: hrdata_next = {31'h00000000, busy};
               `OCSL_REG_RB:     hrdata_next = {16'h0000, rb_reg};
               `OCSL_REG_DIV:    hrdata_next = {16'h0000, div_reg};
               default:          hrdata_next = 32'h00000000;
            endcase
         end
      end
      // Changing the word or the rate mid-sequence would corrupt the frame.
      if (wrPend_reg && !busy && addr_reg == `OCSL_REG_CFG) begin
         cfg_next = hwdata[15:0];
      end
      if (wrPend_reg && !busy && addr_reg == `OCSL_REG_DIV) begin
         div_next = hwdata[15:0];
      end
   end

   always_comb begin
      state_next  = state_reg;
      mode_next   = mode_reg;
      rb_next     = rb_reg;
      cnt_next    = cnt_reg;
      csN_next    = csN_reg;
      sclk_next   = sclk_reg;
      hdata_next  = hdata_reg;
      hoe_next    = hoe_reg;
      prog_next   = prog_reg;
      divCnt_next = (!busy || tick) ? 16'h0000 : divCnt_reg + 16'h0001;
      unique case (state_reg)
         HS_IDLE: begin
            if (start && (hwdata[`OCSL_CMD_WRITE] || hwdata[`OCSL_CMD_READ])) begin
               mode_next  = hwdata[`OCSL_CMD_WRITE] ? HM_WRITE : HM_READ;
               state_next = HS_PRE;
               csN_next   = 1'b0;
               hdata_next = 1'b1;
               hoe_next   = 1'b1;
            end else if (start && hwdata[`OCSL_CMD_BURN]) begin
               mode_next  = HM_BURN;
               state_next = HS_CLKLO;
               cnt_next   = 4'h0;
               prog_next  = 1'b1;
               hdata_next = 1'b1;
               hoe_next   = 1'b1;
            end
         end
         HS_PRE: begin
            if (tick) begin
               state_next = HS_ENTER;
               csN_next   = 1'b1;
            end
         end
         HS_ENTER: begin
            if (tick && mode_reg == HM_READ) begin
               state_next = HS_RBDROP;
               csN_next   = 1'b0;
               hoe_next   = 1'b0;
            end else if (tick) begin
               state_next = HS_CLKLO;
               cnt_next   = 4'h0;
               hdata_next = cfg_reg[`OCSL_CCW_BIT];
            end
         end
         HS_RBDROP: begin
            if (tick) begin
               state_next = HS_RBEN;
               csN_next   = 1'b1;
            end
         end
         HS_RBEN: begin
            if (tick) begin
               state_next = HS_RBANA;
               csN_next   = 1'b0;
            end
         end
         HS_RBANA: begin
            if (tick) begin
               state_next = HS_CLKLO;
               cnt_next   = 4'h0;
            end
         end
         HS_CLKLO: begin
            if (tick) begin
               state_next = HS_CLKHI;
               sclk_next  = 1'b1;
            end
         end
         HS_CLKHI: begin
            if (tick) begin
               sclk_next = 1'b0;
               cnt_next  = nxt;
               if (mode_reg == HM_READ) begin
                  rb_next[cnt_reg] = pin2_reg;
               end
               if (mode_reg == HM_WRITE) begin
                  hdata_next = cfg_reg[~nxt];
               end
               if (cnt_reg == 4'hF) begin
                  state_next = HS_IDLE;
                  prog_next  = 1'b0;
                  hoe_next   = 1'b0;
                  csN_next   = 1'b1;
               end else begin
                  state_next = HS_CLKLO;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         state_reg  <= HS_IDLE;
         mode_reg   <= HM_WRITE;
         cfg_reg    <= 16'h0000;
         rb_reg     <= 16'h0000;
         div_reg    <= `OCSL_DIV_RESET;
         divCnt_reg <= 16'h0000;
         cnt_reg    <= 4'h0;
         csN_reg    <= 1'b1;
         sclk_reg   <= 1'b0;
         hdata_reg  <= 1'b0;
         hoe_reg    <= 1'b0;
         prog_reg   <= 1'b0;
         pin1_reg   <= 1'b0;
         pin2_reg   <= 1'b0;
         wrPend_reg <= 1'b0;
         addr_reg   <= 8'h00;
         hrdata_reg <= 32'h00000000;
      end else begin
         state_reg  <= state_next;
         mode_reg   <= mode_next;
         cfg_reg    <= cfg_next;
         rb_reg     <= rb_next;
         div_reg    <= div_next;
         divCnt_reg <= divCnt_next;
         cnt_reg    <= cnt_next;
         csN_reg    <= csN_next;
         sclk_reg   <= sclk_next;
         hdata_reg  <= hdata_next;
         hoe_reg    <= hoe_next;
         prog_reg   <= prog_next;
         pin1_reg   <= link.dataPin;
         pin2_reg   <= pin1_reg;
         wrPend_reg <= wrPend_next;
         addr_reg   <= addr_next;
         hrdata_reg <= hrdata_next;
      end
   end

   assign hreadyout         = 1'b1;
   assign hresp             = 1'b0;
   assign hrdata            = hrdata_reg;
   assign link.frameSelectN = csN_reg;
   assign link.serialClock  = sclk_reg;
   assign link.hostData     = hdata_reg;
   assign link.hostDataOe   = hoe_reg;
   assign link.progLevel    = prog_reg;
endmodule

/* testbench/ocsl_sva.sv */
// Purpose: Protocol checks on the configuration link between the two ends.
// Assumes: One clock domain; nrst stands for the power-on reset.
// Notes:   A serial clock high phase must last at least 8 clock cycles.
`timescale 1ns/1ps
module ocsl_sva (
   input wire logic clock,
   input wire logic nrst,
   input wire logic frameSelectN,
   input wire logic serialClock,
   input wire logic hostData,
   input wire logic hostDataOe,
   input wire logic progLevel,
   input wire logic devData,
   input wire logic devDataOe,
   input wire logic readbackRef
);
   logic [4:0] burnClkReg;
   logic [4:0] burnClkNext;
   logic       sclkReg;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // Counter clears when the level drops, so a new burn starts from zero.
   always_comb begin
      burnClkNext = burnClkReg;
      if (!nrst || !progLevel) burnClkNext = 5'h00;
      else if (serialClock && !sclkReg) burnClkNext = burnClkReg + 5'h01;
   end
   always_ff @(posedge clock) begin
      burnClkReg <= burnClkNext;
      sclkReg <= serialClock;
   end
   sequence s_clkHigh;
      serialClock [*8];
   endsequence
   sequence s_dataHeld;
      $stable(hostData) [*4];
   endsequence
   property p_noClash;
      !(hostDataOe && devDataOe);
   endproperty
   property p_outEnable;
      $rose(devDataOe) |-> frameSelectN && !hostDataOe;
   endproperty
   property p_refLevel;
      $rose(readbackRef) |-> !frameSelectN && devDataOe;
   endproperty
   property p_refEnd;
      $fell(readbackRef) |-> serialClock && devDataOe;
   endproperty
   property p_bitOut;
      devDataOe && $past(devDataOe) && $changed(devData) |-> serialClock;
   endproperty
   property p_clkHigh;
      $rose(serialClock) |-> s_clkHigh;
   endproperty
   property p_dataHeld;
      $rose(serialClock) && hostDataOe |-> s_dataHeld;
   endproperty
   property p_burnEntry;
      $rose(progLevel) |-> hostDataOe && hostData;
   endproperty
   property p_burnCount;
      $fell(progLevel) |-> burnClkReg == 5'h10;
   endproperty
   property p_writeEntry;
      $rose(frameSelectN) && hostDataOe |-> hostData;
   endproperty
   a_noClash: assert property (p_noClash)
      else $error("data pin driven by both ends");
   a_outEnable: assert property (p_outEnable)
      else $error("pin output enabled away from a select rise");
   a_refLevel: assert property (p_refLevel)
      else $error("reference level outside select low");
   a_refEnd: assert property (p_refEnd)
      else $error("reference level left without a clock rise");
   a_bitOut: assert property (p_bitOut)
      else $error("readback bit changed with clock low");
   a_clkHigh: assert property (p_clkHigh)
      else $error("serial clock high phase too short");
   a_dataHeld: assert property (p_dataHeld)
      else $error("host data moved around a clock rise");
   a_burnEntry: assert property (p_burnEntry)
      else $error("programming level without pin driven high");
   a_burnCount: assert property (p_burnCount)
      else $error("burn did not give sixteen clocks");
   a_writeEntry: assert property (p_writeEntry)
      else $error("select rose with host driving the pin low");
endmodule

/* testbench/testbench.sv */
// Purpose: Drives the programmer end over AHB-Lite against the sensor end.
// Assumes: A short PWM step keeps one output period near 8194 cycles, or 16388 with the halve bit set.
// Notes:   The fuse array is modelled here and survives a reset.
`timescale 1ns/1ps
`include "ocsl_defs.svh"
module testbench;
   import ocsl_pkg::*;
   logic        clock = 1'b0;
   logic        nrst = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        fieldRed = 1'b0;
   logic        linRaw = 1'b0;
   logic [11:0] rawAngle = 12'h0;
   logic [11:0] angle;
   logic        pwmOut, fieldRiseFlag, fieldFallFlag, linAlarm, fuseBurn;
   ocsl_word_t  fuseBits = 16'h0201;
   ocsl_word_t  fuseBurnData, activeCfg, burnFirst;
   int          errTotal = 0, checksDone = 0, burnSeen = 0;
   ocsl_if      link();
   always #2 clock = ~clock;
   ocsl_host u_ocsl_host (.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link));
   ocsl_device #(.STEP_NS(8)) u_ocsl_device (.clock(clock), .nrst(nrst), .link(link),
      .fuseBits(fuseBits), .fuseBurn(fuseBurn), .fuseBurnData(fuseBurnData),
      .activeCfg(activeCfg), .rawAngle(rawAngle), .movingCloser(1'b1), .movingAway(1'b0),
      .fieldOut(1'b0), .fieldRed(fieldRed), .linRaw(linRaw), .angle(angle), .pwmOut(pwmOut),
      .fieldRiseFlag(fieldRiseFlag), .fieldFallFlag(fieldFallFlag), .linAlarm(linAlarm));
   ocsl_sva u_sva (.clock(clock), .nrst(nrst), .frameSelectN(link.frameSelectN),
      .serialClock(link.serialClock), .hostData(link.hostData), .hostDataOe(link.hostDataOe),
      .progLevel(link.progLevel), .devData(link.devData), .devDataOe(link.devDataOe),
      .readbackRef(link.readbackRef));
   // A burn pulse can only set fuse bits, never clear them.
   always @(posedge clock) begin
      if (fuseBurn === 1'b1) begin
         if (burnSeen == 0) burnFirst <= fuseBurnData;
         fuseBits <= fuseBits | fuseBurnData;
         burnSeen <= burnSeen + 1;
      end
   end
   task automatic complete_run;
      if (errTotal == 0 && checksDone > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         errTotal++;
      end
   endtask
   task automatic phase(inout int n);
      do begin
         @(posedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
   endtask
   task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      hsize <= 3'h2;
      htrans <= 2'h2;
      phase(n);
      htrans <= 2'h0;
      hwdata <= wd;
      phase(n);
      rd = hrdata;
      check("hresp", 32'h0, {31'h0, hresp});
      if (n >= 100) begin
         errTotal++;
         complete_run;
      end
   endtask
   task automatic wait_idle;
      logic [31:0] s;
      int          k;
      s = 32'h1;
      for (k = 0; k < 2000 && s[0] !== 1'b0; k++) bus(`OCSL_REG_STATUS, 1'b0, 32'h0, s);
      if (k == 2000) begin
         errTotal++;
         complete_run;
      end
   endtask
   task automatic do_reset;
      nrst <= 1'b0;
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      repeat (4) @(posedge clock);
   endtask
   task automatic t_regs;
      logic [31:0] d;
      bus(`OCSL_REG_DIV, 1'b0, 32'h0, d);
      check("div", 32'h14, d);
      bus(`OCSL_REG_DIV, 1'b1, 32'h0000000A, d);
      bus(`OCSL_REG_DIV, 1'b0, 32'h0, d);
      check("divWrite", 32'hA, d);
      bus(`OCSL_REG_DIV, 1'b1, 32'h00000014, d);
      bus(8'h20, 1'b1, 32'hFFFF, d);
      bus(8'h20, 1'b0, 32'h0, d);
      check("unmapped", 32'h0, d);
   endtask
   // The PWM count spans one whole period, so the phase of its start does not matter.
   task automatic t_write(input ocsl_word_t w, input logic [11:0] raw);
      logic [31:0] d;
      logic [11:0] a;
      int          n;
      rawAngle <= raw;
      fieldRed <= raw[0];
      linRaw <= raw[1];
      bus(`OCSL_REG_CFG, 1'b1, {16'h0, w}, d);
      bus(`OCSL_REG_CFG, 1'b0, 32'h0, d);
      check("cfg", {16'h0, w}, d);
      bus(`OCSL_REG_CTRL, 1'b1, 32'h1, d);
      wait_idle;
      repeat (10) @(posedge clock);
      check("activeCfg", {16'h0, w}, {16'h0, activeCfg});
      a = w[15] ? w[14:3] - raw : raw - w[14:3];
      check("angle", {20'h0, a}, {20'h0, angle});
      check("flags", {29'h0, w[1] ? {3{raw[0]}} : {2'h2, raw[1]}},
            {29'h0, fieldRiseFlag, fieldFallFlag, linAlarm});
      repeat (16388) @(posedge clock);
      n = 0;
      repeat (8194 * (w[0] + 1)) begin
         @(posedge clock);
         n += (pwmOut === 1'b1);
      end
      check("pwmHigh", w[2] ? 0 : (a + 1) * 2 * (w[0] + 1), n);
   endtask
   task automatic t_burn(input ocsl_word_t w);
      logic [31:0] d;
      ocsl_word_t  f;
      f = fuseBits;
      bus(`OCSL_REG_CTRL, 1'b1, 32'h2, d);
      wait_idle;
      check("burnCount", 32'd16, burnSeen);
      check("burnData", {16'h0, w & ~f}, {16'h0, burnFirst});
      check("held", {16'h0, w}, {16'h0, activeCfg});
      bus(`OCSL_REG_CFG, 1'b1, {16'h0, ~w}, d);
      bus(`OCSL_REG_CTRL, 1'b1, 32'h1, d);
      wait_idle;
      repeat (10) @(posedge clock);
      check("locked", {16'h0, w}, {16'h0, activeCfg});
      do_reset;
      check("fused", {16'h0, f | w}, {16'h0, activeCfg});
      bus(`OCSL_REG_CTRL, 1'b1, 32'h4, d);
      wait_idle;
      bus(`OCSL_REG_RB, 1'b0, 32'h0, d);
      check("readback", {16'h0, f | w}, d);
   endtask
   initial begin
      do_reset;
      t_regs;
      t_write(16'h0801, 12'h123);
      t_write(16'h87FE, 12'h0F0);
      t_write(16'h4000, 12'h7FF);
      t_burn(16'h4000);
      complete_run;
   end
endmodule
